// ### verilog/sdf_pkg.sv
`default_nettype none
package sdf_pkg;
  localparam int DATA_W = 24;
  localparam int RATIO_W = 8;
  localparam int MODE_W = 8;
  localparam int MD_MSB = 2;
  localparam int CHOP_OFF_BIT = 3;
  localparam int CONV_EN_BIT = 5;
  localparam int NOTCH_BIT = 6;
  localparam int GAIN_FRAC = 23;
  localparam int PROD_W = 2 * DATA_W + 2;
  localparam int SCL_W = PROD_W - GAIN_FRAC;
  localparam int WARM_OUTPUTS = 3;
  localparam logic [2:0] MD_IDLE = 3'h1;
  localparam logic [2:0] MD_ZS_INT = 3'h4;
  localparam logic [2:0] MD_FS_INT = 3'h5;
  localparam logic [2:0] MD_ZS_SYS = 3'h6;
  localparam logic [2:0] MD_FS_SYS = 3'h7;
  localparam logic [MODE_W-1:0] MODE_RESET = 8'h01;
  localparam logic [RATIO_W-1:0] RATIO_RESET = 8'h45;
  localparam logic [RATIO_W-1:0] RATIO_MIN_CHOP = 8'h0d;
  localparam logic [RATIO_W-1:0] RATIO_MIN_PLAIN = 8'h03;
  localparam logic [RATIO_W-1:0] NOTCH_MIN_RATIO = 8'h44;
  localparam logic [DATA_W-1:0] MID_SCALE = 24'h800000;
  localparam logic [DATA_W-1:0] FULL_CODE = 24'hffffff;

  typedef enum logic [1:0] {
    SRC_PINS = 2'h0,
    SRC_ZERO = 2'h1,
    SRC_REF = 2'h2
  } src_sel_t;

  typedef enum logic [2:0] {
    CAL_IDLE = 3'b001,
    CAL_SETTLE = 3'b010,
    CAL_MEASURE = 3'b100
  } cal_state_t;

  typedef struct packed {
    logic [DATA_W-1:0] offset;
    logic [DATA_W-1:0] gain;
  } coef_t;

  typedef struct packed {
    logic ready;
    logic cal_error;
    logic ref_missing;
  } status_t;
endpackage : sdf_pkg
`default_nettype wire

// ### verilog/sinc3_decim.sv
`timescale 1ns/1ps
`default_nettype none
module sinc3_decim
  import sdf_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  input wire logic i_clk_en,
  input wire logic i_bit,
  input wire logic i_restart,
  input wire logic [RATIO_W-1:0] i_ratio,
  output logic o_valid,
  output logic [DATA_W-1:0] o_data
);
  // Wrapping sums are exact here: a ones stream gives at most 255 cubed.
  logic [DATA_W-1:0] int1_q, int2_q, int3_q;
  logic [DATA_W-1:0] dly1_q, dly2_q, dly3_q;
  logic [DATA_W-1:0] comb1, comb2, comb3;
  logic [RATIO_W-1:0] cnt_q;
  logic [1:0] warm_q;
  logic tick;

  assign tick = (cnt_q >= i_ratio - 8'h01);
  assign comb1 = int3_q - dly1_q;
  assign comb2 = comb1 - dly2_q;
  assign comb3 = comb2 - dly3_q;

  // [R1] Sinc3 integrate stage.
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      int1_q <= '0;
      int2_q <= '0;
      int3_q <= '0;
    end else if (i_clk_en) begin
      if (i_restart) begin
        int1_q <= '0;
        int2_q <= '0;
        int3_q <= '0;
      end else begin
        int1_q <= int1_q + {{(DATA_W-1){1'b0}}, i_bit};
        int2_q <= int2_q + int1_q;
        int3_q <= int3_q + int2_q;
      end
    end
  end

  // [R1] Decimate and comb.
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cnt_q <= '0;
      warm_q <= '0;
      dly1_q <= '0;
      dly2_q <= '0;
      dly3_q <= '0;
      o_valid <= 1'b0;
      o_data <= '0;
    end else if (i_clk_en) begin
      o_valid <= 1'b0;
      if (i_restart) begin
        cnt_q <= '0;
        warm_q <= '0;
        dly1_q <= '0;
        dly2_q <= '0;
        dly3_q <= '0;
      end else if (tick) begin
        cnt_q <= '0;
        dly1_q <= int3_q;
        dly2_q <= comb1;
        dly3_q <= comb2;
        o_data <= comb3;
        // The first outputs after a restart still hold the flushed history.
        if (warm_q == 2'(WARM_OUTPUTS))
          o_valid <= 1'b1;
        else
          warm_q <= warm_q + 2'h1;
      end else begin
        cnt_q <= cnt_q + 8'h01;
      end
    end
  end
endmodule : sinc3_decim
`default_nettype wire

// ### verilog/sdf_backend.sv
`timescale 1ns/1ps
`default_nettype none
// What this block does
// [R1] Sinc3 decimator filters the bitstream; the ratio register sets its rate.
// [R2] Mode bit 6 enables the fixed notch stage; cleared bypasses it.
// [R3] Software enables the notch only for ratio words of 68 or more.
// [R4] Chop swaps inputs and averages each filter output with the previous.
// [R5] Mode bit 3 set disables chopping; clear keeps chop and averaging.
// [R6] Mode field 100 starts internal zero cal; 101 internal full cal.
// [R7] Mode field 110 starts system zero cal; 111 system full cal.
// [R8] After reset the factory coefficients load into the calibration registers.
// [R9] A user calibration overwrites the factory coefficient it measures.
// [R10] Software enables the converter before requesting a calibration.
// [R11] Zero cal result goes to offset; full cal result goes to gain.
// [R12] Internal calibrations route the zero or reference source to the inputs.
// [R13] For system calibration the outside applies the voltages beforehand.
// [R14] Calibration conversions use the currently programmed ratio word.
// [R15] Outputs are corrected by subtracting offset, then multiplying by gain.
// [R16] The ready flag marks the end of a calibration.
// [R17] A missing reference halts calibration at once, registers untouched.
// [R18] Software runs zero calibration before full calibration.
// [R19] Internal full calibration measures the reference at unity gain.
// [R20] In bipolar mode zero cal maps zero input to code 800000.
// [R21] Software picks the slowest update rate before calibrating.
// [R22] A reference-inhibited calibration sets the calibration error flag.
// [R23] With chop on, ratio words below 13 act as 13; maximum 255.
// [R24] After a calibration ends the mode field returns to idle.
module sdf_backend
  import sdf_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  input wire logic i_clk_en,
  input wire logic i_mod_bit,
  input wire logic i_ref_missing,
  input wire logic i_bipolar,
  input wire logic i_mode_wr,
  input wire logic [MODE_W-1:0] i_mode_wdata,
  input wire logic i_ratio_wr,
  input wire logic [RATIO_W-1:0] i_ratio_wdata,
  input wire logic i_ready_clr,
  input wire logic i_error_clr,
  input wire coef_t i_factory_coef,
  output logic [MODE_W-1:0] o_mode_reg,
  output logic [RATIO_W-1:0] o_decim_ratio,
  output logic [DATA_W-1:0] o_result,
  output coef_t o_coef,
  output status_t o_status,
  output src_sel_t o_input_src,
  output logic o_force_unity_gain,
  output logic o_chop_swap
);
  logic [1:0] pin_s1_q, pin_s2_q;
  logic mod_bit, ref_missing_flag;
  logic [MODE_W-1:0] mode_q;
  logic [RATIO_W-1:0] ratio_q, eff_ratio;
  coef_t coef_q;
  logic load_pend_q;
  cal_state_t state_q;
  logic [2:0] cal_md_q;
  logic swap_q, have_prev_q, restart;
  logic [DATA_W-1:0] last_sinc_q, prev_notch_q;
  logic sinc_valid;
  logic [DATA_W-1:0] sinc_data, notch_data, conv_data, corrected;
  logic conv_valid, chop_on, notch_on, cal_busy, cal_req;
  logic cal_done, cal_abort, res_we;
  logic [DATA_W:0] notch_sum, chop_sum;
  logic signed [DATA_W:0] diff;
  logic signed [PROD_W-1:0] prod;
  logic signed [SCL_W-1:0] scaled, biased;

  // Both pins come from outside; the first stage feeds only the second.
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
    end else if (i_clk_en) begin
      pin_s1_q <= {i_ref_missing, i_mod_bit};
      pin_s2_q <= pin_s1_q;
    end
  end
  assign ref_missing_flag = pin_s2_q[1];
  // [R4] Swapped inputs are undone by inverting the bitstream.
  assign mod_bit = pin_s2_q[0] ^ swap_q;

  // [R5] Chop bit polarity.
  assign chop_on = !mode_q[CHOP_OFF_BIT];
  // [R2] Notch enable.
  assign notch_on = mode_q[NOTCH_BIT];
  assign cal_busy = (state_q != CAL_IDLE);
  // [R10] Calibration waits for the converter enable bit.
  assign cal_req = mode_q[MD_MSB] && mode_q[CONV_EN_BIT];

  // [R23] Ratio floor depends on chop; 8 bits cap it at 255.
  always_comb begin
    if (chop_on && ratio_q < RATIO_MIN_CHOP)
      eff_ratio = RATIO_MIN_CHOP;
    else if (ratio_q < RATIO_MIN_PLAIN)
      eff_ratio = RATIO_MIN_PLAIN;
    else
      eff_ratio = ratio_q;
  end

  // [R14] Calibration uses the same programmed ratio as conversions.
  sinc3_decim u_sinc (
    .i_clk_sys(i_clk_sys),
    .i_reset_n(i_reset_n),
    .i_clk_en(i_clk_en),
    .i_bit(mod_bit),
    .i_restart(restart),
    .i_ratio(eff_ratio),
    .o_valid(sinc_valid),
    .o_data(sinc_data)
  );

  // [R2] Two-tap notch on successive filter words, bypassed when off.
  assign notch_sum = {1'b0, sinc_data} + {1'b0, last_sinc_q};
  assign notch_data = notch_on ? notch_sum[DATA_W:1] : sinc_data;
  // [R4] Average with the previous output while chopping.
  assign chop_sum = {1'b0, notch_data} + {1'b0, prev_notch_q};
  assign conv_data = chop_on ? chop_sum[DATA_W:1] : notch_data;
  assign conv_valid = sinc_valid && (!chop_on || have_prev_q);

  // [R4] Chop swap and averaging history.
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      swap_q <= 1'b0;
      have_prev_q <= 1'b0;
      last_sinc_q <= '0;
      prev_notch_q <= '0;
    end else if (i_clk_en) begin
      if (restart) begin
        have_prev_q <= 1'b0;
      end else if (sinc_valid) begin
        swap_q <= chop_on ? !swap_q : 1'b0;
        have_prev_q <= 1'b1;
        last_sinc_q <= sinc_data;
        prev_notch_q <= notch_data;
      end
    end
  end

  // [R15] Subtract offset, then scale by gain in Q1.23.
  always_comb begin
    diff = $signed({1'b0, conv_data}) - $signed({1'b0, coef_q.offset});
    prod = diff * $signed({1'b0, coef_q.gain});
    scaled = prod[PROD_W-1:GAIN_FRAC];
    // [R20] Bipolar zero maps to mid-scale.
    biased = scaled + (i_bipolar ? $signed(SCL_W'(MID_SCALE)) : '0);
    if (biased < 0)
      corrected = '0;
    else if (biased > $signed(SCL_W'(FULL_CODE)))
      corrected = FULL_CODE;
    else
      corrected = biased[DATA_W-1:0];
  end

  assign res_we = conv_valid && !cal_busy && mode_q[CONV_EN_BIT];
  // [R17] Missing reference aborts a calibration in progress.
  assign cal_abort = cal_busy && ref_missing_flag;
  assign cal_done = (state_q == CAL_MEASURE) && conv_valid && !cal_abort;
  assign restart = (state_q == CAL_IDLE) && cal_req;

  // [R6] [R7] Calibration sequencer; the first word after a source change
  // is discarded because the filter still holds the old input.
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_q <= CAL_IDLE;
      cal_md_q <= MD_IDLE;
    end else if (i_clk_en) begin
      case (state_q)
        CAL_IDLE: begin
          if (cal_req) begin
            state_q <= CAL_SETTLE;
            cal_md_q <= mode_q[MD_MSB:0];
          end
        end
        CAL_SETTLE: begin
          if (cal_abort)
            state_q <= CAL_IDLE;
          else if (conv_valid)
            state_q <= CAL_MEASURE;
        end
        CAL_MEASURE: begin
          if (cal_abort || conv_valid)
            state_q <= CAL_IDLE;
        end
        default: state_q <= CAL_IDLE;
      endcase
    end
  end

  // [R12] [R19] Source routing for internal cals; forced unity gain for internal full cal only.
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_input_src <= SRC_PINS;
      o_force_unity_gain <= 1'b0;
    end else if (i_clk_en) begin
      o_force_unity_gain <= cal_busy && (cal_md_q == MD_FS_INT);
      if (cal_busy && cal_md_q == MD_ZS_INT)
        o_input_src <= SRC_ZERO;
      else if (cal_busy && cal_md_q == MD_FS_INT)
        o_input_src <= SRC_REF;
      else
        o_input_src <= SRC_PINS;
    end
  end

  // [R8] [R9] [R11] Factory load after reset, then user cal results.
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      load_pend_q <= 1'b1;
      coef_q <= '0;
    end else if (i_clk_en) begin
      if (load_pend_q) begin
        load_pend_q <= 1'b0;
        coef_q <= i_factory_coef;
      end else if (cal_done) begin
        if (cal_md_q == MD_ZS_INT || cal_md_q == MD_ZS_SYS)
          coef_q.offset <= conv_data;
        else
          coef_q.gain <= conv_data;
      end
    end
  end

  // [R24] Software write wins; otherwise an ended cal returns to idle.
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      mode_q <= MODE_RESET;
      ratio_q <= RATIO_RESET;
    end else if (i_clk_en) begin
      if (i_mode_wr)
        mode_q <= i_mode_wdata;
      else if (cal_done || cal_abort)
        mode_q[MD_MSB:0] <= MD_IDLE;
      if (i_ratio_wr)
        ratio_q <= i_ratio_wdata;
    end
  end

  // [R16] [R22] Sticky ready and error flags; a new event wins over the clear.
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_status <= '0;
      o_result <= '0;
    end else if (i_clk_en) begin
      o_status.ref_missing <= ref_missing_flag;
      if (res_we || cal_done || cal_abort)
        o_status.ready <= 1'b1;
      else if (i_ready_clr)
        o_status.ready <= 1'b0;
      if (cal_abort)
        o_status.cal_error <= 1'b1;
      else if (i_error_clr || restart)
        o_status.cal_error <= 1'b0;
      if (res_we)
        o_result <= corrected;
    end
  end

  assign o_mode_reg = mode_q;
  assign o_decim_ratio = ratio_q;
  assign o_coef = coef_q;
  assign o_chop_swap = swap_q;

  sequence cal_finish;
    i_clk_en && cal_done;
  endsequence
  sequence cal_halt;
    i_clk_en && cal_abort;
  endsequence

  // [R24] Mode field idles.
  md_idle_after_a: assert property (@(posedge i_clk_sys) // [R24]
    disable iff (!i_reset_n) (cal_finish or cal_halt) and !i_mode_wr
    |=> mode_q[MD_MSB:0] == MD_IDLE) else $error("mode field not idled");
  // [R17] Abort leaves coefficients.
  abort_no_write_a: assert property (@(posedge i_clk_sys) // [R17]
    disable iff (!i_reset_n) cal_halt ##0 !load_pend_q
    |=> coef_q == $past(coef_q)) else $error("coef written on abort");
  // [R22] Error flag raised.
  abort_err_flag_a: assert property (@(posedge i_clk_sys) // [R22]
    disable iff (!i_reset_n) cal_halt |=> o_status.cal_error && !cal_busy)
    else $error("abort did not flag error");
  // [R16] Ready after cal.
  cal_ready_set_a: assert property (@(posedge i_clk_sys) // [R16]
    disable iff (!i_reset_n) cal_finish |=> o_status.ready && !cal_busy)
    else $error("ready not set at cal end");
  // [R12] Zero source routed.
  zero_src_route_a: assert property (@(posedge i_clk_sys) // [R12]
    disable iff (!i_reset_n) i_clk_en && cal_busy && cal_md_q == MD_ZS_INT
    |=> o_input_src == SRC_ZERO) else $error("zero source not routed");
  // [R19] Unity gain forced.
  unity_gain_fs_a: assert property (@(posedge i_clk_sys) // [R19]
    disable iff (!i_reset_n) i_clk_en && cal_busy && cal_md_q == MD_FS_INT
    |=> o_force_unity_gain && o_input_src == SRC_REF)
    else $error("full-scale cal not at unity gain");
  // [R11] Offset stored.
  offset_store_a: assert property (@(posedge i_clk_sys) // [R11]
    disable iff (!i_reset_n) cal_finish ##0 (cal_md_q == MD_ZS_SYS ||
    cal_md_q == MD_ZS_INT) |=> coef_q.offset == $past(conv_data))
    else $error("offset not stored");
  // [R8] Factory coefficients.
  factory_load_a: assert property (@(posedge i_clk_sys) // [R8]
    disable iff (!i_reset_n) i_clk_en && load_pend_q
    |=> coef_q == $past(i_factory_coef) && !load_pend_q)
    else $error("factory coefficients not loaded");
  // [R20] Bipolar mid-scale.
  bipolar_mid_a: assert property (@(posedge i_clk_sys) // [R20]
    disable iff (!i_reset_n) i_clk_en && res_we && i_bipolar &&
    conv_data == coef_q.offset |=> o_result == MID_SCALE)
    else $error("bipolar zero not mid-scale");
  // [R23] Chop ratio floor.
  chop_ratio_floor_a: assert property (@(posedge i_clk_sys) // [R23]
    disable iff (!i_reset_n) chop_on |-> eff_ratio >= RATIO_MIN_CHOP)
    else $error("chop ratio below floor");
endmodule : sdf_backend
`default_nettype wire

// ### testbench/mod_stream.sv
`timescale 1ns/1ps
`default_nettype none
module mod_stream
  import sdf_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_level,
  input wire src_sel_t i_src,
  output logic o_bit
);
  // Pins carry the applied level.
  // Internal sources override the pins, as the loop itself would see them.
  always_ff @(posedge i_clk_sys) begin
    case (i_src)
      SRC_ZERO: o_bit <= 1'b0;
      SRC_REF: o_bit <= 1'b1;
      default: o_bit <= i_level;
    endcase
  end
endmodule : mod_stream
`default_nettype wire

// ### testbench/tb_sdf_backend.sv
`timescale 1ns/1ps
`default_nettype none
module tb_sdf_backend;
  import sdf_pkg::*;
  logic i_clk_sys, i_reset_n, i_clk_en, i_mod_bit, i_ref_missing, i_bipolar;
  logic i_mode_wr, i_ratio_wr, i_ready_clr, i_error_clr, lvl, sw;
  logic [MODE_W-1:0] i_mode_wdata, o_mode_reg;
  logic [RATIO_W-1:0] i_ratio_wdata, o_decim_ratio;
  logic [DATA_W-1:0] o_result, res;
  coef_t i_factory_coef, o_coef, keep;
  status_t o_status;
  src_sel_t o_input_src;
  logic o_force_unity_gain, o_chop_swap;
  int n_mismatch, samples_checked, cyc, t0, n;
  int rt[4] = '{5, 2, 255, 20};
  logic [7:0] md[4] = '{8'h21, 8'h29, 8'h21, 8'h29};
  int per[4] = '{13, 3, 255, 20};
  src_sel_t cal_src[4] = '{SRC_ZERO, SRC_REF, SRC_PINS, SRC_PINS};
  longint fo, fg, fs;

  sdf_backend dut_u (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n),
    .i_clk_en(i_clk_en), .i_mod_bit(i_mod_bit),
    .i_ref_missing(i_ref_missing), .i_bipolar(i_bipolar),
    .i_mode_wr(i_mode_wr), .i_mode_wdata(i_mode_wdata),
    .i_ratio_wr(i_ratio_wr), .i_ratio_wdata(i_ratio_wdata),
    .i_ready_clr(i_ready_clr), .i_error_clr(i_error_clr),
    .i_factory_coef(i_factory_coef), .o_mode_reg(o_mode_reg),
    .o_decim_ratio(o_decim_ratio), .o_result(o_result), .o_coef(o_coef),
    .o_status(o_status), .o_input_src(o_input_src),
    .o_force_unity_gain(o_force_unity_gain), .o_chop_swap(o_chop_swap));
  mod_stream part_u (.i_clk_sys(i_clk_sys), .i_level(lvl),
    .i_src(o_input_src), .o_bit(i_mod_bit));

  function automatic longint cube(int k);
    return longint'(k) * k * k;
  endfunction : cube
  function automatic logic [23:0] corr(longint raw, longint off,
                                       longint g, logic bip);
    longint v;
    v = ((raw - off) * g) >>> 23;
    if (bip) v += 64'sd8388608;
    if (v < 0) v = 0;
    if (v > 64'sd16777215) v = 64'sd16777215;
    return v[23:0];
  endfunction : corr

  task automatic conclude;
    if (n_mismatch == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : conclude
  task automatic chk(input string nm, input logic [47:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic tick;
    @(posedge i_clk_sys);
    #10;
  endtask : tick
  task automatic wr(input logic m, input logic [7:0] v);
    if (m) i_mode_wr = 1'b1;
    else i_ratio_wr = 1'b1;
    i_mode_wdata = v;
    i_ratio_wdata = v;
    tick;
    if (m) i_mode_wr = 1'b0;
    else i_ratio_wr = 1'b0;
  endtask : wr
  task automatic clr;
    i_ready_clr = 1'b1;
    tick;
    i_ready_clr = 1'b0;
  endtask : clr
  task automatic wait_rdy;
    int k;
    k = 0;
    while (o_status.ready !== 1'b1 && k < 2000) begin
      tick;
      k++;
    end
    if (k == 2000) chk("ready wait", 0, 1);
  endtask : wait_rdy
  // A stale word may already wait and a ratio change spoils three more.
  // The notch also averages the word before the clean one, so read six.
  task automatic settle;
    repeat (6) begin
      wait_rdy;
      res = o_result;
      clr;
    end
  endtask : settle

  initial begin
    i_clk_sys = 1'b0;
    forever #50 i_clk_sys = ~i_clk_sys;
  end
  always @(posedge i_clk_sys) begin
    cyc++;
    if (cyc == 60000) begin
      n_mismatch++;
      conclude;
    end
  end

  initial begin
    {i_reset_n, i_ref_missing, i_bipolar, i_mode_wr, i_ratio_wr} = '0;
    {i_ready_clr, i_error_clr, i_mode_wdata, i_ratio_wdata} = '0;
    i_clk_en = 1'b1;
    lvl = 1'b1;
    void'($urandom(24));
    i_factory_coef.offset = $urandom_range(0, 40);
    i_factory_coef.gain = $urandom_range(24'h400000, 24'hffffff);
    fo = i_factory_coef.offset;
    fg = i_factory_coef.gain;
    fs = cube(255);
    repeat (6) tick;
    i_reset_n = 1'b1;
    tick;
    tick;
    chk("mode reset", o_mode_reg, MODE_RESET);
    chk("ratio reset", o_decim_ratio, RATIO_RESET);
    chk("factory coef", o_coef, i_factory_coef);
    n = $urandom_range(3, 30);
    wr(0, n);
    wr(1, 8'h29);
    chk("ratio reg", o_decim_ratio, n);
    settle;
    chk("plain result", res, corr(cube(n), fo, fg, 0));
    i_bipolar = 1'b1;
    settle;
    chk("bip result", res, corr(cube(n), fo, fg, 1));
    i_bipolar = 1'b0;
    for (int i = 0; i < 4; i++) begin
      wr(0, rt[i]);
      wr(1, md[i]);
      settle;
      wait_rdy;
      t0 = cyc;
      sw = o_chop_swap;
      clr;
      wait_rdy;
      chk("word period", cyc - t0, per[i]);
      chk("swap toggles", o_chop_swap ^ sw, !md[i][3]);
      clr;
    end
    // Notch only with ratio of 68 or more.
    wr(0, 8'h52);
    wr(1, 8'h69);
    settle;
    chk("notch result", res, corr(cube(82), fo, fg, 0));
    // Zero calibration first, each code in turn, at the slowest rate.
    wr(0, 8'hff);
    for (int c = 4; c < 8; c++) begin
      lvl = (c != 5);
      wr(1, 8'h28 | c);
      repeat (4) tick;
      chk("cal source", o_input_src, cal_src[c-4]);
      chk("unity gain", o_force_unity_gain, c == 5);
      // A conversion word may land on the start edge; clear once busy.
      clr;
      wait_rdy;
      chk("field idle", o_mode_reg[2:0], MD_IDLE);
      res = c[0] ? o_coef.gain : o_coef.offset;
      chk("cal coef", res, c == 4 ? 0 : fs);
      clr;
    end
    lvl = 1'b1;
    i_bipolar = 1'b1;
    settle;
    chk("mid scale", res, MID_SCALE);
    i_bipolar = 1'b0;
    keep = o_coef;
    wr(1, 8'h2c);
    tick;
    clr;
    repeat (2) tick;
    i_ref_missing = 1'b1;
    repeat (6) tick;
    chk("abort ready", o_status.ready, 1);
    chk("abort coef", o_coef, keep);
    chk("abort field", o_mode_reg[2:0], MD_IDLE);
    chk("cal error", o_status.cal_error, 1);
    chk("ref flag", o_status.ref_missing, 1);
    i_ref_missing = 1'b0;
    i_error_clr = 1'b1;
    tick;
    i_error_clr = 1'b0;
    repeat (4) tick;
    chk("error clear", o_status.cal_error, 0);
    wr(1, 8'h0c);
    clr;
    repeat (300) tick;
    chk("no start", o_status.ready, 0);
    chk("no src", o_input_src, SRC_PINS);
    chk("coef kept", o_coef, keep);
    // With the clock enable low a ratio write must not land.
    i_clk_en = 1'b0;
    wr(0, 8'h11);
    chk("frozen ratio", o_decim_ratio, 8'hff);
    i_clk_en = 1'b1;
    wr(1, 8'h29);
    conclude;
  end
endmodule : tb_sdf_backend
`default_nettype wire
